// [core/daq_trigger_timing.sv]
// acquisition trigger and timing block with apb control
// ==========================================
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module daq_trigger_timing #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_convert_n_in,
    output logic ext_convert_n_out,
    output logic ext_convert_n_oe,
    input wire logic acq_start_trigger_n,
    input wire logic pretrigger_stop_input,
    output logic scan_pulse_out,
    output logic ext_latch_pulse_n,
    output logic conv_start
);
    // refuse counter widths that the register bus cannot serve
    if (CNT_W < 2 || CNT_W > 32)
    begin
        $error("CNT_W out of range");
    end
    // ==========================================
    // state
    typedef enum {ST_IDLE, ST_ARMED, ST_RUN} acq_t;
    typedef struct packed {
        logic [daq_timing_pkg::CTRL_W-1:0] ctrl;
        logic [CNT_W-1:0] interval;
        logic [CNT_W-1:0] count_load;
        logic [CNT_W-1:0] tick;
        logic [CNT_W-1:0] remain;
        logic [CNT_W-1:0] convs;
        logic counting;
        logic done;
        logic conv_prev;
        logic start_prev;
        logic stop_prev;
        logic tc_out;
        logic conv_go;
        logic strobe_go;
        logic [daq_timing_pkg::TMR_W-1:0] latch_low;
        logic [31:0] rdata;
        acq_t acq;
    } top_state_t;
    top_state_t st;
    top_state_t next_st;
    logic conv_s;
    logic start_s;
    logic stop_s;
    logic apb_wr;
    logic apb_rd;
    logic ext_mode;
    // ==========================================
    // pin synchronisers
    sync2 u_sync_conv (.pclk(pclk), .presetn(presetn), .din(ext_convert_n_in),
        .dout(conv_s));
    sync2 u_sync_start (.pclk(pclk), .presetn(presetn), .din(acq_start_trigger_n),
        .dout(start_s));
    sync2 #(.RESET_VAL(1'b1)) u_sync_stop (.pclk(pclk), .presetn(presetn), // idles on pull-up
        .din(pretrigger_stop_input), .dout(stop_s));
    // apb decode, zero wait states
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign ext_mode = st.ctrl[daq_timing_pkg::CTRL_EXT_CONV];
    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == daq_timing_pkg::ADDR_CTRL) || (a == daq_timing_pkg::ADDR_INTERVAL)
            || (a == daq_timing_pkg::ADDR_COUNT) || (a == daq_timing_pkg::ADDR_STROBE)
            || (a == daq_timing_pkg::ADDR_STATUS) || (a == daq_timing_pkg::ADDR_CONVS);
    endfunction
    // ==========================================
    // next-state logic
    always_comb
    begin
        next_st = st;
        next_st.conv_go = 1'b0;
        next_st.strobe_go = 1'b0;
        next_st.conv_prev = conv_s;
        next_st.start_prev = start_s;
        next_st.stop_prev = stop_s;
        // register writes
        if (apb_wr)
        begin
            unique case (paddr)
                daq_timing_pkg::ADDR_CTRL:
                    next_st.ctrl = pwdata[daq_timing_pkg::CTRL_W-1:0];
                daq_timing_pkg::ADDR_INTERVAL:
                    next_st.interval = pwdata[CNT_W-1:0];
                daq_timing_pkg::ADDR_COUNT:
                    next_st.count_load = pwdata[CNT_W-1:0];
                daq_timing_pkg::ADDR_STROBE:
                    next_st.strobe_go = 1'b1;
                default:
                    next_st.strobe_go = 1'b0;
            endcase
        end
        // read data capture in setup phase
        if (apb_rd)
        begin
            unique case (paddr)
                daq_timing_pkg::ADDR_CTRL:
                    next_st.rdata = 32'(st.ctrl);
                daq_timing_pkg::ADDR_INTERVAL:
                    next_st.rdata = 32'(st.interval);
                daq_timing_pkg::ADDR_COUNT:
                    next_st.rdata = 32'(st.remain);
                daq_timing_pkg::ADDR_STATUS:
                    next_st.rdata = 32'({st.done, st.counting, st.acq == ST_RUN,
                        st.acq == ST_ARMED});
                daq_timing_pkg::ADDR_CONVS:
                    next_st.rdata = 32'(st.convs);
                default:
                    next_st.rdata = daq_timing_pkg::RESET_WORD;
            endcase
        end
        // external pacing: rising edge of synchronised convert input
        if (ext_mode && conv_s && !st.conv_prev)
            next_st.conv_go = 1'b1;
        // acquisition sequencer
        unique case (st.acq)
            ST_IDLE:
            begin
                next_st.tc_out = 1'b1;
                if (st.ctrl[daq_timing_pkg::CTRL_ARM] && !ext_mode)
                begin
                    next_st.acq = ST_ARMED;
                    next_st.remain = st.count_load;
                    next_st.done = 1'b0;
                    next_st.counting = !st.ctrl[daq_timing_pkg::CTRL_PRETRIG];
                end
            end
            ST_ARMED:
            begin
                if (ext_mode || !st.ctrl[daq_timing_pkg::CTRL_ARM])
                    next_st.acq = ST_IDLE;
                else if (!start_s && st.start_prev)
                begin
                    next_st.acq = ST_RUN;
                    next_st.tick = st.interval;
                end
            end
            ST_RUN:
            begin
                if (ext_mode || !st.ctrl[daq_timing_pkg::CTRL_ARM])
                    next_st.acq = ST_IDLE;
                else if (st.tick <= 1)
                begin
                    next_st.tick = st.interval;
                    next_st.conv_go = 1'b1;
                    next_st.tc_out = 1'b0;
                    if (st.counting)
                    begin
                        if (st.remain <= 1)
                        begin
                            next_st.remain = '0;
                            next_st.done = 1'b1;
                            next_st.acq = ST_IDLE;
                            next_st.ctrl[daq_timing_pkg::CTRL_ARM] = 1'b0;
                        end
                        else
                            next_st.remain = st.remain - 1'b1;
                    end
                end
                else
                begin
                    next_st.tick = st.tick - 1'b1;
                    next_st.tc_out = 1'b1;
                end
                if (st.ctrl[daq_timing_pkg::CTRL_PRETRIG] && stop_s && !st.stop_prev)
                    next_st.counting = 1'b1;
            end
            default:
                next_st.acq = ST_IDLE;
        endcase
        // low-time tally of the strobe pin, saturating
        if (ext_latch_pulse_n)
            next_st.latch_low = '0;
        else if (st.latch_low != '1)
            next_st.latch_low = st.latch_low + 1'b1;
        if (next_st.conv_go)
            next_st.convs = st.convs + 1'b1;
    end
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.interval <= CNT_W'(daq_timing_pkg::INTERVAL_RESET);
            st.conv_prev <= 1'b1;
            st.start_prev <= 1'b1;
            st.stop_prev <= 1'b1;
            st.tc_out <= 1'b1;
            st.acq <= ST_IDLE;
        end
        else
            st <= next_st;
    end
    // ==========================================
    // pulse outputs
    logic scan_raw_n;
    pulse_timer #(.LEN(daq_timing_pkg::SCAN_LOW_CYC)) u_scan (.pclk(pclk),
        .presetn(presetn), .fire(st.conv_go && st.ctrl[daq_timing_pkg::CTRL_SCAN_EN]),
        .pulse_n(scan_raw_n));
    pulse_timer #(.LEN(daq_timing_pkg::STROBE_CYC)) u_strobe (.pclk(pclk),
        .presetn(presetn), .fire(st.strobe_go), .pulse_n(ext_latch_pulse_n));
    assign scan_pulse_out = scan_raw_n;
    assign conv_start = st.conv_go;
    // convert line: counter output driven only under internal pacing
    assign ext_convert_n_out = st.tc_out;
    assign ext_convert_n_oe = !ext_mode;
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !known_addr(paddr);
    // ==========================================
    // checks
    // strobe pin falls the cycle after the register write is seen
    a_strobe_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st.strobe_go) |=> !ext_latch_pulse_n)
        else $error("strobe pulse did not start");
    // strobe pin stays low for the full strobe width
    a_strobe_width: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ext_latch_pulse_n)
        |-> st.latch_low == daq_timing_pkg::TMR_W'(daq_timing_pkg::STROBE_CYC))
        else $error("strobe pulse wrong width");
    // scan pin stays high while scanning is off
    a_scan_idle_high: assert property (@(posedge pclk) disable iff (!presetn)
        !st.ctrl[daq_timing_pkg::CTRL_SCAN_EN] && $stable(st.ctrl) && scan_pulse_out
        |=> scan_pulse_out)
        else $error("scan pulse while disabled");
    // scan pin falls after each conversion start while scanning is on
    a_scan_fall: assert property (@(posedge pclk) disable iff (!presetn)
        st.conv_go && st.ctrl[daq_timing_pkg::CTRL_SCAN_EN] |=> !scan_pulse_out)
        else $error("scan pulse missing");
    // external convert rise answered within the start limit
    a_ext_conv_go: assert property (@(posedge pclk) disable iff (!presetn)
        ext_mode && $rose(ext_convert_n_in) ##1 ext_mode [*3] |-> ##[0:1] st.conv_go)
        else $error("external convert late");
    // convert line released under external pacing
    a_release_line: assert property (@(posedge pclk) disable iff (!presetn)
        ext_mode |-> !ext_convert_n_oe)
        else $error("convert line driven in external mode");
    // the convert line falls only together with a conversion start
    a_conv_line_low: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ext_convert_n_out) |-> conv_start)
        else $error("convert line pulse without conversion");
    // no paced conversion before the start edge
    a_no_early_conv: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_mode && st.acq != ST_RUN |=> !st.conv_go)
        else $error("conversion before start trigger");
    // start trigger has no effect under external pacing
    a_start_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        ext_mode && st.acq != ST_RUN |=> st.acq != ST_RUN)
        else $error("start trigger acted in external mode");
    // a full sample interval is loaded on the start edge
    a_first_interval: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st.acq == ST_RUN) |-> st.tick == $past(st.interval))
        else $error("first interval not loaded");
    // a stop edge during the run enables sample counting
    a_stop_counts: assert property (@(posedge pclk) disable iff (!presetn)
        st.acq == ST_RUN && st.ctrl[daq_timing_pkg::CTRL_PRETRIG] && stop_s && !st.stop_prev
        |=> st.counting)
        else $error("stop edge did not enable counting");
    // samples are not counted before the stop edge
    a_pretrig_hold: assert property (@(posedge pclk) disable iff (!presetn)
        st.acq == ST_RUN && !st.counting && st.tick <= 1 |=> st.remain == $past(st.remain))
        else $error("samples counted before stop edge");
    // acquisition ends only with the sample count at zero
    a_done_zero: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st.done) |-> st.remain == '0 && st.acq == ST_IDLE)
        else $error("acquisition ended with count left");
    // arm clears itself as the acquisition ends
    a_done_disarm: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st.done) |-> !st.ctrl[daq_timing_pkg::CTRL_ARM])
        else $error("arm left set after acquisition end");
    // conversion count read back as it stood in the setup cycle
    a_rd_capture: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == daq_timing_pkg::ADDR_CONVS
        |=> prdata == 32'($past(st.convs)))
        else $error("read data not captured");
endmodule
`default_nettype wire

// [core/pulse_timer.sv]
// fixed-length low pulse generator, retriggerable
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
    parameter int LEN = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    output logic pulse_n
);
    // refuse lengths that the down-counter cannot hold
    if (LEN < 1 || LEN >= (1 << daq_timing_pkg::TMR_W))
    begin
        $error("pulse_timer LEN out of range");
    end
    typedef struct packed {
        logic [daq_timing_pkg::TMR_W-1:0] cnt;
        logic out_n;
    } pt_state_t;
    pt_state_t st;
    pt_state_t next_st;
    // load on fire, count down, release high at zero
    always_comb
    begin
        next_st = st;
        if (fire)
        begin
            next_st.cnt = daq_timing_pkg::TMR_W'(LEN);
            next_st.out_n = 1'b0;
        end
        else if (st.cnt > 1)
            next_st.cnt = st.cnt - 1'b1;
        else
        begin
            next_st.cnt = '0;
            next_st.out_n = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '{cnt: '0, out_n: 1'b1};
        else
            st <= next_st;
    end
    assign pulse_n = st.out_n;
endmodule
`default_nettype wire

// [core/sync2.sv]
// two-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic dout
);
    logic stage1;
    // stage1 feeds only dout
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= RESET_VAL;
            dout <= RESET_VAL;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

// [inc/daq_timing_pkg.sv]
// shared constants for the acquisition trigger and timing block
package daq_timing_pkg;
    // clock rate
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_NS = 20;
    // documented times in ns
    localparam int SCAN_LOW_NS = 1000;
    localparam int STROBE_NS = 200;
    localparam int CONV_START_MAX_NS = 250;
    localparam int TRIG_MIN_NS = 50;
    // derived counts: scan and strobe widths round down (typical), at least one
    localparam int SCAN_LOW_CYC = (SCAN_LOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (SCAN_LOW_NS / CLK_PERIOD_NS);
    localparam int STROBE_CYC = (STROBE_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (STROBE_NS / CLK_PERIOD_NS);
    localparam int CONV_START_MAX_CYC = (CONV_START_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (CONV_START_MAX_NS / CLK_PERIOD_NS);
    localparam int TMR_W = 6;
    // apb register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INTERVAL = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_STROBE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CONVS = 8'h14;
    // control fields
    localparam int CTRL_SCAN_EN = 0;
    localparam int CTRL_EXT_CONV = 1;
    localparam int CTRL_PRETRIG = 2;
    localparam int CTRL_ARM = 3;
    localparam int CTRL_W = 4;
    // status fields
    localparam int STAT_ARMED = 0;
    localparam int STAT_RUN = 1;
    localparam int STAT_COUNTING = 2;
    localparam int STAT_DONE = 3;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] INTERVAL_RESET = 32'h0000_0064;
endpackage

// [test/daq_trigger_timing_tb_top.sv]
// self-checking bench for the acquisition trigger and timing block
`timescale 1ns/1ps
`default_nettype none
module daq_trigger_timing_tb_top;
    // ==========================================
    // clock, reset and pins
    localparam int IV = 20;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, conv_out, conv_oe, conv_start, scan, latch_n;
    logic far_n, far_en, start_n, stop_lvl, conv_line;
    int n_mismatch = 0;
    int num_checks = 0;
    int rise_at, fall_at, conv_at, n_conv, n_scan, n_line, n_latch;
    // convert line: device, else far source, else pull-up
    assign conv_line = conv_oe ? conv_out : (far_en ? far_n : 1'b1);
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    daq_trigger_timing dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_convert_n_in(conv_line), .ext_convert_n_out(conv_out),
        .ext_convert_n_oe(conv_oe), .acq_start_trigger_n(start_n),
        .pretrigger_stop_input(stop_lvl), .scan_pulse_out(scan),
        .ext_latch_pulse_n(latch_n), .conv_start(conv_start));
    ext_instruments u_far (.pclk(pclk), .conv_drv_n(far_n), .conv_drv_en(far_en),
        .start_n(start_n), .stop_lvl(stop_lvl));
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            n_mismatch++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // observe pins for n cycles and tally events
    task automatic watch(input int n);
        logic pl, ps;
        pl = conv_line;
        ps = start_n;
        rise_at = -1;
        fall_at = -1;
        conv_at = -1;
        n_conv = 0;
        n_scan = 0;
        n_line = 0;
        n_latch = 0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge pclk);
            #1;
            if (!pl && conv_line)
                rise_at = i;
            if (ps && !start_n && fall_at < 0)
                fall_at = i;
            if (conv_start === 1'b1)
            begin
                if (conv_at < 0)
                    conv_at = i;
                n_conv++;
            end
            n_scan += (scan === 1'b0);
            n_latch += (latch_n === 1'b0);
            n_line += (conv_oe === 1'b1 && conv_line === 1'b0);
            pl = conv_line;
            ps = start_n;
        end
    endtask
    // ==========================================
    // scenarios
    task automatic t_basic();
        check({28'h0, scan, latch_n, conv_oe, conv_start}, 32'h0000_000E);
        rdchk(daq_timing_pkg::ADDR_CTRL, daq_timing_pkg::RESET_WORD);
        rdchk(daq_timing_pkg::ADDR_INTERVAL, daq_timing_pkg::INTERVAL_RESET);
        apb(1'b1, daq_timing_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        rdchk(daq_timing_pkg::ADDR_STATUS, 32'h0000_0000);
        rdchk(8'h18, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        apb(1'b1, daq_timing_pkg::ADDR_STROBE, 32'h0000_0001);
        watch(30);
        check(n_latch, daq_timing_pkg::STROBE_CYC);
    endtask
    task automatic t_ext();
        apb(1'b1, daq_timing_pkg::ADDR_CTRL, 32'h0000_000B);
        fork
            u_far.pulse_start();
            watch(150);
        join
        check({31'h0, conv_oe}, 32'h0000_0000);
        check(n_conv, 0);
        fork
            u_far.pulse_convert(8);
            watch(90);
        join
        check(rise_at >= 0 && conv_at >= rise_at, 1);
        check(conv_at - rise_at <= daq_timing_pkg::CONV_START_MAX_CYC, 1);
        check(n_scan, daq_timing_pkg::SCAN_LOW_CYC);
        apb(1'b1, daq_timing_pkg::ADDR_CTRL, 32'h0000_0002);
        fork
            u_far.pulse_convert(3);
            watch(90);
        join
        check(n_conv, 1);
        check(n_scan, 0);
    endtask
    task automatic t_paced(input logic pre);
        do_reset();
        rdchk(daq_timing_pkg::ADDR_CONVS, 32'h0000_0000);
        apb(1'b1, daq_timing_pkg::ADDR_INTERVAL, IV);
        apb(1'b1, daq_timing_pkg::ADDR_COUNT, pre ? 32'h0000_0002 : 32'h0000_0003);
        apb(1'b1, daq_timing_pkg::ADDR_CTRL, pre ? 32'h0000_000D : 32'h0000_0009);
        check({31'h0, conv_oe}, 32'h0000_0001);
        fork
            u_far.pulse_start();
            watch(pre ? 100 : 150);
        join
        check(fall_at >= 0 && conv_at - fall_at <= IV + 4, 1);
        if (pre)
        begin
            check(n_conv >= 3, 1);
            apb(1'b0, daq_timing_pkg::ADDR_STATUS, 32'h0000_0000);
            check({rd[daq_timing_pkg::STAT_COUNTING], rd[daq_timing_pkg::STAT_DONE]}, 0);
            rdchk(daq_timing_pkg::ADDR_COUNT, 32'h0000_0002);
            fork
                u_far.stop_rise();
                watch(120);
            join
        end
        else
        begin
            check(n_conv, 3);
            check(n_line, 3);
            rdchk(daq_timing_pkg::ADDR_CONVS, 32'h0000_0003);
        end
        apb(1'b0, daq_timing_pkg::ADDR_STATUS, 32'h0000_0000);
        check(rd[daq_timing_pkg::STAT_DONE], 1);
        rdchk(daq_timing_pkg::ADDR_COUNT, 32'h0000_0000);
        watch(60);
        check(n_conv, 0);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_basic();
        t_ext();
        t_paced(1'b0);
        t_paced(1'b1);
        complete_run();
    end
endmodule
`default_nettype wire

// [test/ext_instruments.sv]
// behavioural model of the external trigger sources and convert driver
`timescale 1ns/1ps
`default_nettype none
module ext_instruments (
    input wire logic pclk,
    output logic conv_drv_n,
    output logic conv_drv_en,
    output logic start_n,
    output logic stop_lvl
);
    // ==========================================
    // trigger drivers
    // shortest legal phase, 50 ns rounded up to whole clocks
    localparam int MIN_CYC = 3;
    // idle: nothing driven on the convert line, start high, stop low
    initial
    begin
        conv_drv_n = 1'b1;
        conv_drv_en = 1'b0;
        start_n = 1'b1;
        stop_lvl = 1'b0;
    end
    // active-low convert pulse, line released afterwards
    task automatic pulse_convert(input int low_cyc);
        int n;
        n = (low_cyc < MIN_CYC) ? MIN_CYC : low_cyc;
        @(posedge pclk);
        conv_drv_en <= 1'b1;
        conv_drv_n <= 1'b0;
        repeat (n) @(posedge pclk);
        conv_drv_n <= 1'b1;
        repeat (MIN_CYC) @(posedge pclk);
        conv_drv_en <= 1'b0;
    endtask
    // falling edge on the start pin, then back high
    task automatic pulse_start();
        @(posedge pclk);
        start_n <= 1'b0;
        repeat (MIN_CYC + 2) @(posedge pclk);
        start_n <= 1'b1;
        repeat (MIN_CYC) @(posedge pclk);
    endtask
    // rising edge on the stop pin
    task automatic stop_rise();
        @(posedge pclk);
        stop_lvl <= 1'b0;
        repeat (MIN_CYC) @(posedge pclk);
        stop_lvl <= 1'b1;
        repeat (MIN_CYC) @(posedge pclk);
    endtask
endmodule
`default_nettype wire
